//--- include/tal_defs.svh
// Constants of the turbo anti-lag supervisor: widths, timing counts, reset values.
// Assumes inclusion by bare name from package and design files.
`ifndef TAL_DEFS_SVH
`define TAL_DEFS_SVH
`define TAL_CLK_HZ 125000000
`define TAL_SEC_CYCLES (`TAL_CLK_HZ)
`define TAL_PWM_DIV_W 24
`define TAL_RST_FLAG 1'h0
`define TAL_RST_SEC 8'h00
`define TAL_RST_PRESC 27'h000_0000
`endif

//--- include/tal_pkg.sv
// Types of the turbo anti-lag supervisor.
// Assumes tal_defs.svh is on the include path.
`include "tal_defs.svh"
package tal_pkg;
    typedef enum logic [1:0] {
        TAL_IDLE,
        TAL_RUN,
        TAL_GAP
    } tal_state_t;
    typedef enum logic [1:0] {
        TAL_INJ_SEQUENTIAL,
        TAL_INJ_SEMI,
        TAL_INJ_BATCH
    } tal_inj_mode_t;
endpackage

//--- design/tal_supervisor.sv
// Turbo anti-lag supervisor: qualifies arming and limits, runs the run-time
// and gap timers, and produces fuel, timing, cut, idle valve and output controls.
// Assumes sensors arrive as already-scaled values synchronous to clk_sys_i,
// except the arming switch, which is a raw pin. Table lookups are outside;
// this block only supplies the axis values and routes the results.
`timescale 1ns/1ps
`include "tal_defs.svh"
module tal_supervisor (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic clk_en_i,
    // Arming switch pin, raw
    input wire logic arm_switch_i,
    // Sensors
    input wire logic [9:0] throttle_position_i,
    input wire logic [9:0] pedal_position_i,
    input wire logic [15:0] engine_speed_i,
    input wire logic signed [11:0] intake_air_temperature_i,
    input wire logic signed [11:0] coolant_temperature_i,
    input wire logic pulse_event_i,
    input wire logic inj_event_i,
    input wire logic spark_event_i,
    // Configuration
    input wire logic elec_throttle_i,
    input wire logic [9:0] max_throttle_i,
    input wire logic [15:0] min_speed_i,
    input wire logic [15:0] max_speed_i,
    input wire logic signed [11:0] max_air_temp_i,
    input wire logic signed [11:0] min_coolant_i,
    input wire logic signed [11:0] max_coolant_i,
    input wire logic [7:0] max_run_sec_i,
    input wire logic [7:0] gap_sec_i,
    input wire logic [1:0] inj_mode_i,
    input wire logic fuel_cut_en_i,
    input wire logic spark_cut_en_i,
    input wire logic roving_cut_en_i,
    input wire logic [6:0] roving_cut_pct_i,
    input wire logic idle_valve_en_i,
    input wire logic idle_stepper_i,
    input wire logic [7:0] idle_extra_duty_i,
    input wire logic [7:0] idle_extra_steps_i,
    input wire logic pwm_out_en_i,
    input wire logic [7:0] pwm_duty_i,
    input wire logic [23:0] pwm_period_i,
    // Table results, looked up at the axis values below
    input wire logic [7:0] tbl_added_fuel_i,
    input wire logic signed [7:0] tbl_timing_i,
    input wire logic [6:0] tbl_fuel_cut_pct_i,
    input wire logic [6:0] tbl_spark_cut_pct_i,
    // Outputs
    output logic [9:0] tbl_axis_load_o,
    output logic [15:0] tbl_axis_speed_o,
    output logic active_o,
    output logic [7:0] added_fuel_o,
    output logic timing_override_o,
    output logic signed [7:0] timing_abs_o,
    output logic inj_cut_o,
    output logic spark_cut_o,
    output logic [7:0] idle_duty_add_o,
    output logic [7:0] idle_steps_add_o,
    output logic onoff_out_o,
    output logic pwm_out_o,
    output logic [7:0] run_sec_o
);
    typedef struct packed {
        logic rst_s1;
        logic rst_s2;
        logic arm_s1;
        logic arm_s2;
        tal_pkg::tal_state_t state;
        logic [26:0] presc;
        logic [7:0] run_sec;
        logic [7:0] gap_sec;
        logic [6:0] fuel_acc;
        logic [6:0] spark_acc;
        logic [6:0] rove_acc;
        logic [23:0] pwm_cnt;
        logic [9:0] axis_load;
        logic [15:0] axis_speed;
        logic active;
        logic [7:0] added_fuel;
        logic timing_ovr;
        logic signed [7:0] timing_abs;
        logic inj_cut;
        logic spark_cut;
        logic [7:0] idle_duty;
        logic [7:0] idle_steps;
        logic pwm_out;
    } tal_regs_t;

    tal_regs_t r;
    tal_regs_t next_r;
    logic rst_n;
    logic [9:0] load_pos;
    logic cond_ok;
    logic sec_tick;
    logic seq_inj;
    logic [7:0] fuel_sum;
    logic [7:0] spark_sum;
    logic [7:0] rove_sum;
    logic [31:0] duty_prod;

    // Reset is released through the first two state bits
    assign rst_n = r.rst_s2;

    // Electronic throttle compares pedal position, throttle may open further
    assign load_pos = elec_throttle_i ? pedal_position_i : throttle_position_i;
    // All sensor limits combined with the synchronised arming switch
    assign cond_ok = r.arm_s2
        && (load_pos <= max_throttle_i)
        && (engine_speed_i >= min_speed_i)
        && (engine_speed_i <= max_speed_i)
        && (intake_air_temperature_i <= max_air_temp_i)
        && (coolant_temperature_i >= min_coolant_i)
        && (coolant_temperature_i <= max_coolant_i);
    assign sec_tick = (r.presc == 27'(`TAL_SEC_CYCLES - 1));
    // Injection cut patterns only defined for fully sequential firing
    assign seq_inj = (inj_mode_i == 2'(tal_pkg::TAL_INJ_SEQUENTIAL));
    // Accumulator sums: reaching 100 or more marks an event to cut
    assign fuel_sum = {1'b0, r.fuel_acc} + {1'b0, tbl_fuel_cut_pct_i};
    assign spark_sum = {1'b0, r.spark_acc} + {1'b0, tbl_spark_cut_pct_i};
    assign rove_sum = {1'b0, r.rove_acc} + {1'b0, roving_cut_pct_i};
    assign duty_prod = 32'(pwm_period_i) * 32'(pwm_duty_i);

    // Next-state logic
    always_comb begin
        logic go;
        go = 1'b0;
        next_r = r;
        next_r.rst_s1 = 1'b1;
        next_r.rst_s2 = r.rst_s1;
        next_r.arm_s1 = arm_switch_i;
        next_r.arm_s2 = r.arm_s1;
        // Axis values for every table lookup
        next_r.axis_load = load_pos;
        next_r.axis_speed = engine_speed_i;
        next_r.presc = sec_tick ? 27'h000_0000 : r.presc + 27'h000_0001;
        unique case (r.state)
            tal_pkg::TAL_IDLE: begin
                if (cond_ok) begin
                    next_r.state = tal_pkg::TAL_RUN;
                    next_r.run_sec = `TAL_RST_SEC;
                    next_r.presc = `TAL_RST_PRESC;
                end
            end
            tal_pkg::TAL_RUN: begin
                if (sec_tick && r.run_sec != 8'hFF) begin
                    next_r.run_sec = r.run_sec + 8'h01;
                end
                if (!cond_ok) begin
                    // Short drop-out keeps the same activation and timer
                    next_r.state = tal_pkg::TAL_GAP;
                    next_r.gap_sec = `TAL_RST_SEC;
                end
            end
            tal_pkg::TAL_GAP: begin
                // Timer keeps counting across the drop-out; limit still applies
                if (sec_tick && r.run_sec != 8'hFF) begin
                    next_r.run_sec = r.run_sec + 8'h01;
                end
                if (sec_tick) begin
                    next_r.gap_sec = r.gap_sec + 8'h01;
                end
                if (cond_ok) begin
                    next_r.state = tal_pkg::TAL_RUN;
                end else if (r.gap_sec >= gap_sec_i) begin
                    next_r.state = tal_pkg::TAL_IDLE;
                end
            end
        endcase
        // Active only inside one activation, all conditions met, time left
        go = (next_r.state == tal_pkg::TAL_RUN) && cond_ok
            && (next_r.run_sec < max_run_sec_i);
        next_r.active = go;
        // Fuel and absolute timing from the tables, cleared when inactive
        next_r.added_fuel = go ? tbl_added_fuel_i : 8'h00;
        next_r.timing_ovr = go;
        next_r.timing_abs = go ? tbl_timing_i : 8'sh00;
        next_r.inj_cut = 1'b0;
        next_r.spark_cut = 1'b0;
        // Rotating fuel cut: accumulator spreads cuts over the cylinders
        if (inj_event_i && go && fuel_cut_en_i && seq_inj) begin
            next_r.inj_cut = (fuel_sum >= 8'h64);
            next_r.fuel_acc = (fuel_sum >= 8'h64) ? 7'(fuel_sum - 8'h64) : fuel_sum[6:0];
        end
        // Roving idle cut, only outside anti-lag
        if (inj_event_i && !go && roving_cut_en_i && seq_inj) begin
            next_r.inj_cut = (rove_sum >= 8'h64);
            next_r.rove_acc = (rove_sum >= 8'h64) ? 7'(rove_sum - 8'h64) : rove_sum[6:0];
        end
        if (spark_event_i && go && spark_cut_en_i) begin
            next_r.spark_cut = (spark_sum >= 8'h64);
            next_r.spark_acc = (spark_sum >= 8'h64) ? 7'(spark_sum - 8'h64) : spark_sum[6:0];
        end
        // Idle valve: duty for a PWM valve, steps for a stepper
        next_r.idle_duty = (go && idle_valve_en_i && !idle_stepper_i)
            ? idle_extra_duty_i : 8'h00;
        next_r.idle_steps = (go && idle_valve_en_i && idle_stepper_i)
            ? idle_extra_steps_i : 8'h00;
        // Fixed duty PWM; period in clock cycles, duty in percent
        if (go && pwm_out_en_i && pwm_period_i != 24'h00_0000) begin
            next_r.pwm_cnt = (r.pwm_cnt >= pwm_period_i - 24'h00_0001)
                ? 24'h00_0000 : r.pwm_cnt + 24'h00_0001;
            next_r.pwm_out = (32'(r.pwm_cnt) * 32'h0000_0064) < duty_prod;
        end else begin
            next_r.pwm_cnt = 24'h00_0000;
            next_r.pwm_out = 1'b0;
        end
        if (pulse_event_i) begin
            next_r.presc = r.presc;
        end
    end

    // State register; clock enable freezes everything once the reset release is done
    always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            r <= '0;
        end else if (!rst_n) begin
            r <= '0;
            r.rst_s1 <= 1'b1;
            r.rst_s2 <= r.rst_s1;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end

    assign tbl_axis_load_o = r.axis_load;
    assign tbl_axis_speed_o = r.axis_speed;
    assign active_o = r.active;
    assign added_fuel_o = r.added_fuel;
    assign timing_override_o = r.timing_ovr;
    assign timing_abs_o = r.timing_abs;
    assign inj_cut_o = r.inj_cut;
    assign spark_cut_o = r.spark_cut;
    assign idle_duty_add_o = r.idle_duty;
    assign idle_steps_add_o = r.idle_steps;
    // On/off pin follows the active flag
    assign onoff_out_o = r.active;
    assign pwm_out_o = r.pwm_out;
    assign run_sec_o = r.run_sec;
endmodule

//--- dv/tal_engine_model.sv
// Far-side model: crank-driven injection and spark event pulses.
// Assumes en_i is changed away from the clock edge by the bench.
`timescale 1ns/1ps
module tal_engine_model (
    input wire logic clk_i,
    input wire logic en_i,
    output logic inj_o,
    output logic spark_o
);
    logic [1:0] cnt;
    // Phase restarts when idle so each window gives a known event count
    always_ff @(posedge clk_i) begin
        cnt <= en_i ? cnt + 2'h1 : 2'h0;
    end
    assign inj_o = en_i && cnt == 2'h3;
    assign spark_o = en_i && cnt == 2'h1;
endmodule

//--- dv/tal_supervisor_asserts.sv
// Checker for the anti-lag supervisor, bound to its top module ports.
// Assumes clk_en_i is held high, so every edge is a working edge.
`timescale 1ns/1ps
module tal_supervisor_asserts (
    input wire logic clk_sys_i,
    input wire logic arst_n_i,
    input wire logic arm_switch_i,
    input wire logic elec_throttle_i,
    input wire logic [9:0] throttle_position_i,
    input wire logic [9:0] pedal_position_i,
    input wire logic [9:0] max_throttle_i,
    input wire logic [15:0] engine_speed_i,
    input wire logic [15:0] min_speed_i,
    input wire logic [15:0] max_speed_i,
    input wire logic signed [11:0] intake_air_temperature_i,
    input wire logic signed [11:0] max_air_temp_i,
    input wire logic signed [11:0] coolant_temperature_i,
    input wire logic signed [11:0] min_coolant_i,
    input wire logic signed [11:0] max_coolant_i,
    input wire logic [1:0] inj_mode_i,
    input wire logic inj_event_i,
    input wire logic [7:0] tbl_added_fuel_i,
    input wire logic signed [7:0] tbl_timing_i,
    input wire logic active_o,
    input wire logic [7:0] added_fuel_o,
    input wire logic signed [7:0] timing_abs_o,
    input wire logic inj_cut_o,
    input wire logic onoff_out_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!arst_n_i);
    // Arm pin passes two synchronising stages before the state register
    arm_gates_act_a: assert property (active_o |-> $past(arm_switch_i, 3))
        else $error("active without arming");
    thr_limit_a: assert property ((elec_throttle_i ? pedal_position_i : throttle_position_i)
        > max_throttle_i |=> !active_o) else $error("active above throttle limit");
    speed_window_a: assert property ((engine_speed_i < min_speed_i) ||
        (engine_speed_i > max_speed_i) |=> !active_o) else $error("active outside speed");
    air_temp_a: assert property (intake_air_temperature_i > max_air_temp_i |=> !active_o)
        else $error("active above air temperature");
    coolant_window_a: assert property ((coolant_temperature_i < min_coolant_i) ||
        (coolant_temperature_i > max_coolant_i) |=> !active_o) else $error("coolant window");
    fuel_timing_a: assert property (active_o |-> added_fuel_o == $past(tbl_added_fuel_i)
        && timing_abs_o == $past(tbl_timing_i)) else $error("table values not applied");
    onoff_follow_a: assert property (onoff_out_o == active_o)
        else $error("on/off output differs from active");
    inj_cut_cause_a: assert property (inj_cut_o |-> $past(inj_event_i)
        && $past(inj_mode_i) == 2'h0) else $error("injection cut without sequential event");
endmodule
bind tal_supervisor tal_supervisor_asserts u_chk (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i),
    .arm_switch_i(arm_switch_i), .elec_throttle_i(elec_throttle_i),
    .throttle_position_i(throttle_position_i), .pedal_position_i(pedal_position_i),
    .max_throttle_i(max_throttle_i), .engine_speed_i(engine_speed_i),
    .min_speed_i(min_speed_i), .max_speed_i(max_speed_i),
    .intake_air_temperature_i(intake_air_temperature_i), .max_air_temp_i(max_air_temp_i),
    .coolant_temperature_i(coolant_temperature_i), .min_coolant_i(min_coolant_i),
    .max_coolant_i(max_coolant_i), .inj_mode_i(inj_mode_i), .inj_event_i(inj_event_i),
    .tbl_added_fuel_i(tbl_added_fuel_i), .tbl_timing_i(tbl_timing_i), .active_o(active_o),
    .added_fuel_o(added_fuel_o), .timing_abs_o(timing_abs_o), .inj_cut_o(inj_cut_o),
    .onoff_out_o(onoff_out_o));

//--- dv/test_tal_supervisor.sv
// Self-checking bench: random sensor sweeps, then cut and PWM windows.
// Assumes the one-second tick is never reached, so run time reads zero.
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module test_tal_supervisor;
    logic clk_sys_i = 0, arst_n_i = 0, arm = 0, elec = 0, ev = 0, pen = 0, ival = 0, istep = 0;
    logic [1:0] mode = 2'h0;
    logic [9:0] thr = 10'h000, ped = 10'h000, ax;
    logic [15:0] spd = 16'h0000, axs;
    logic signed [11:0] air = 12'sh000, cool = 12'sh000;
    logic [7:0] fuel = 8'h00, afuel, iduty, isteps, rsec;
    logic signed [7:0] tim = 8'sh00, tabs;
    logic inj, spk, act, tovr, icut, scut, onoff, pwm;
    // Limits and settings live in variables so the bench can move them
    logic [9:0] lim_thr = 10'h0c8;
    logic [15:0] lim_lo = 16'h0bb8, lim_hi = 16'h1770;
    logic signed [11:0] lim_air = 12'sh050, cool_lo = 12'sh03c, cool_hi = 12'sh06e;
    logic [7:0] run_max = 8'h05, gap_max = 8'h02, xduty = 8'h21, xsteps = 8'h0c, pduty = 8'h32;
    logic [6:0] rove_pct = 7'h32, fcut_pct = 7'h19, scut_pct = 7'h32;
    logic [23:0] pper = 24'h00_000a;
    int error_cnt = 0, total_checks = 0, seed = 86, ncut = 0, nspk = 0, npwm = 0;
    tal_engine_model eng (.clk_i(clk_sys_i), .en_i(ev), .inj_o(inj), .spark_o(spk));
    tal_supervisor dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .clk_en_i(1'b1),
        .arm_switch_i(arm), .throttle_position_i(thr), .pedal_position_i(ped),
        .engine_speed_i(spd), .intake_air_temperature_i(air), .coolant_temperature_i(cool),
        .pulse_event_i(1'b0), .inj_event_i(inj), .spark_event_i(spk), .elec_throttle_i(elec),
        .max_throttle_i(lim_thr), .min_speed_i(lim_lo), .max_speed_i(lim_hi),
        .max_air_temp_i(lim_air), .min_coolant_i(cool_lo), .max_coolant_i(cool_hi),
        .max_run_sec_i(run_max), .gap_sec_i(gap_max), .inj_mode_i(mode), .fuel_cut_en_i(1'b1),
        .spark_cut_en_i(1'b1), .roving_cut_en_i(1'b1), .roving_cut_pct_i(rove_pct),
        .idle_valve_en_i(ival), .idle_stepper_i(istep), .idle_extra_duty_i(xduty),
        .idle_extra_steps_i(xsteps), .pwm_out_en_i(pen), .pwm_duty_i(pduty),
        .pwm_period_i(pper), .tbl_added_fuel_i(fuel), .tbl_timing_i(tim),
        .tbl_fuel_cut_pct_i(fcut_pct), .tbl_spark_cut_pct_i(scut_pct), .tbl_axis_load_o(ax),
        .tbl_axis_speed_o(axs), .active_o(act), .added_fuel_o(afuel), .timing_override_o(tovr),
        .timing_abs_o(tabs), .inj_cut_o(icut), .spark_cut_o(scut), .idle_duty_add_o(iduty),
        .idle_steps_add_o(isteps), .onoff_out_o(onoff), .pwm_out_o(pwm), .run_sec_o(rsec));
    always #4 clk_sys_i = ~clk_sys_i;
    // Pulse tallies read the value held before each edge
    always @(posedge clk_sys_i) begin
        ncut += icut;
        nspk += scut;
        npwm += pwm;
    end
    // Expected activity: arming and every sensor limit at once, bounds inclusive
    function automatic logic exp_act();
        return arm && (elec ? ped : thr) <= lim_thr && spd >= lim_lo && spd <= lim_hi
            && air <= lim_air && cool >= cool_lo && cool <= cool_hi;
    endfunction
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Event window of 40 injections and 40 sparks, 170 edges of PWM
    task automatic cut_run(input logic a, input logic [1:0] m, input logic p,
                           input int ec, input int es, input int ep);
        @(posedge clk_sys_i);
        arm <= a;
        mode <= m;
        pen <= p;
        thr <= 10'h064;
        spd <= 16'h0fa0;
        air <= 12'sh014;
        cool <= 12'sh05a;
        repeat (5) @(posedge clk_sys_i);
        #1 ncut = 0;
        nspk = 0;
        npwm = 0;
        ev = 1;
        repeat (160) @(posedge clk_sys_i);
        #1 ev = 0;
        repeat (10) @(posedge clk_sys_i);
        #1 `CHK(ncut, ec)
        `CHK(nspk, es)
        `CHK(npwm, ep)
    endtask
    initial begin
        repeat (3) @(posedge clk_sys_i);
        arst_n_i <= 1;
        repeat (6) @(posedge clk_sys_i);
        // Random sweep with boundary values first; limits sit near the edges
        for (int i = 0; i < 200; i++) begin
            @(posedge clk_sys_i);
            arm <= ($random(seed) % 8) != 0;
            {elec, ival, istep} <= $random(seed);
            thr <= (i < 4) ? 10'h0c8 : 10'({$random(seed)} % 220);
            ped <= (i < 4) ? 10'h0c8 : 10'({$random(seed)} % 220);
            spd <= (i < 4) ? (i[0] ? 16'h0bb8 : 16'h1770) : 16'(2900 + {$random(seed)} % 3200);
            air <= (i < 4) ? 12'sh050 : 12'({$random(seed)} % 90);
            cool <= (i < 4) ? (i[1] ? 12'sh03c : 12'sh06e) : 12'(55 + {$random(seed)} % 60);
            {fuel, tim} <= $random(seed);
            {xduty, xsteps} <= $random(seed);
            repeat (3) @(posedge clk_sys_i);
            #1 `CHK(act, exp_act())
            `CHK(onoff, act)
            `CHK({tovr, afuel}, exp_act() ? {1'b1, fuel} : 9'h000)
            `CHK(tabs, exp_act() ? tim : 8'sh00)
            `CHK(iduty, (exp_act() && ival && !istep) ? xduty : 8'h00)
            `CHK(isteps, (exp_act() && ival && istep) ? xsteps : 8'h00)
            `CHK({ax, axs}, {elec ? ped : thr, spd})
            `CHK(rsec, 8'h00)
        end
        {ival, istep} = 2'b00;
        cut_run(1'b1, 2'h0, 1'b1, 10, 20, 85);
        cut_run(1'b1, 2'h1, 1'b0, 0, 20, 0);
        cut_run(1'b0, 2'h0, 1'b1, 20, 0, 0);
        cut_run(1'b0, 2'h2, 1'b1, 0, 0, 0);
        wrap_up();
    end
    // Hang guard, well beyond the expected run of about 12 us
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
endmodule
